// ### hdl/mip_top.sv
// current, voltage and power monitor core with identification words
// ====================================================
// Notes on behaviour
// - model command returns fixed 16-bit word
// - revision command returns fixed 16-bit word
// - alert selects limit event or conversion ready
// - power valid only with nonzero calibration
// - power LSB equals 25 current LSBs
// - warning limits keep 13 bits, low three zero
// - bus voltage scaling fixed, not calibrated
// - marginal fault alerts within one to two conversions
// - gross overvoltage fault may alert before conversion ends
// - conversion time selectable, 140 us or 1.1 ms
`timescale 1ns/1ns
`include "mip_map.svh"
module mip_top #(
   parameter logic [6:0]  SLAVE_ADDR    = 7'h40,
   // arbitrary neutral identification values
   parameter logic [15:0] MODEL_WORD    = 16'h5A5A,
   parameter logic [15:0] REVISION_WORD = 16'h0102,
   parameter int          AVG_SHIFT     = 2,
   parameter int          CT_FAST_CYC   = `MIP_CT_FAST_NS / `MIP_CLK_NS,
   parameter int          CT_SLOW_CYC   = `MIP_CT_SLOW_NS / `MIP_CLK_NS
) (
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        SRST,
   // serial pins
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE,
   // converter samples
   input  wire logic        ADC_CLK,
   input  wire logic        ADC_SRST,
   input  wire logic        ADC_VALID,
   input  wire logic [15:0] ADC_SHUNT,
   input  wire logic [15:0] ADC_BUS,
   // alert
   output logic             ALERT_N
);
   import mip_pkg::*;

   localparam int CTW = $clog2(CT_SLOW_CYC + 1);
   localparam int NSMP = 1 << AVG_SHIFT;

   mip_ser_if ser ();
   mip_smp_if smp ();

   logic            expect_cmd;
   logic            wr_idx;
   logic [1:0]      rd_idx;
   mip_byte_t       cmd;
   mip_byte_t       lo_byte;
   mip_word_t       cal;
   mip_word_t       cfg;
   mip_word_t       ov_lim;
   mip_word_t       oc_lim;
   mip_word_t       vbus;
   logic signed [15:0] shunt_avg;
   logic signed [15:0] cur;
   logic signed [15:0] pwr;
   logic [CTW-1:0]  ct_cnt;
   logic            conv_end;
   logic [1:0]      chk_pipe;
   logic signed [23:0] acc_shunt;
   logic [23:0]     acc_bus;
   logic [AVG_SHIFT:0] n_smp;
   logic            fault;
   logic            early_trip;
   logic            tele_read;
   mip_word_t       rd_word;
   logic            id_cmd;
   logic signed [31:0] cur_prod;
   logic signed [47:0] pwr_prod;

   // ====================================================
   // serial engine and sample crossing
   mip_serial #(
      .SLAVE_ADDR (SLAVE_ADDR)
   ) u_serial (
      .clk     (REF_CLK),
      .srst    (SRST),
      .scl_in  (SCL_IN),
      .sda_in  (SDA_IN),
      .sda_out (SDA_OUT),
      .sda_oe  (SDA_OE),
      .ser     (ser)
   );

   mip_xfer u_xfer (
      .adc_clk   (ADC_CLK),
      .adc_srst  (ADC_SRST),
      .adc_valid (ADC_VALID),
      .adc_shunt (ADC_SHUNT),
      .adc_bus   (ADC_BUS),
      .clk       (REF_CLK),
      .srst      (SRST),
      .smp       (smp)
   );

   // ====================================================
   // command pointer and byte indices
   always_ff @(posedge REF_CLK) begin
      if (SRST || ser.stop) begin
         expect_cmd <= 1'b1;
         wr_idx     <= 1'b0;
         rd_idx     <= 2'h0;
         if (SRST) cmd <= 8'h00;
      end else if (ser.start) begin
         // repeated start keeps the command for a word read
         expect_cmd <= 1'b1;
         wr_idx     <= 1'b0;
         rd_idx     <= 2'h0;
      end else if (ser.rx_stb) begin
         if (expect_cmd) begin
            cmd        <= ser.rx_byte;
            expect_cmd <= 1'b0;
         end else begin
            wr_idx <= ~wr_idx;
         end
      end else if (ser.tx_load) begin
         rd_idx <= rd_idx + 2'h1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         lo_byte <= 8'h00;
      end else if (ser.rx_stb && !expect_cmd && !wr_idx) begin
         lo_byte <= ser.rx_byte;
      end
   end

   // ====================================================
   // writable registers; a word lands on its high byte
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cal    <= `MIP_CAL_RST;
         cfg    <= `MIP_CFG_RST;
         ov_lim <= `MIP_OV_RST;
         oc_lim <= `MIP_OC_RST;
      end else if (ser.rx_stb && !expect_cmd && wr_idx) begin
         unique case (cmd)
            `MIP_CMD_CAL:    cal <= {ser.rx_byte, lo_byte} & `MIP_CAL_MASK;
            `MIP_CMD_CFG:    cfg <= {ser.rx_byte, lo_byte};
            `MIP_CMD_OV_LIM: ov_lim <= {ser.rx_byte, lo_byte} & `MIP_LIM_MASK;
            `MIP_CMD_OC_LIM: oc_lim <= {ser.rx_byte, lo_byte} & `MIP_LIM_MASK;
            // identification and telemetry codes hold no storage
            default: ;
         endcase
      end
   end

   // ====================================================
   // read mux
   always_comb begin
      unique case (cmd)
         `MIP_CMD_MODEL:  rd_word = MODEL_WORD;
         `MIP_CMD_REV:    rd_word = REVISION_WORD;
         `MIP_CMD_VIN:    rd_word = vbus;
         `MIP_CMD_VOUT:   rd_word = vbus;
         `MIP_CMD_IIN:    rd_word = cur;
         `MIP_CMD_IOUT:   rd_word = cur;
         `MIP_CMD_PIN:    rd_word = pwr;
         `MIP_CMD_CAL:    rd_word = cal;
         `MIP_CMD_CFG:    rd_word = cfg;
         `MIP_CMD_OV_LIM: rd_word = ov_lim;
         `MIP_CMD_OC_LIM: rd_word = oc_lim;
         default:         rd_word = `MIP_UNMAPPED;
      endcase
   end

   // identification words go high byte first, telemetry low byte first
   assign id_cmd = (cmd == `MIP_CMD_MODEL) || (cmd == `MIP_CMD_REV);
   assign ser.tx_byte = (rd_idx[0] ^ id_cmd) ? rd_word[15:8] : rd_word[7:0];
   assign tele_read = ser.tx_load && ((cmd == `MIP_CMD_VIN) || (cmd == `MIP_CMD_VOUT)
                      || (cmd == `MIP_CMD_IIN) || (cmd == `MIP_CMD_IOUT)
                      || (cmd == `MIP_CMD_PIN));

   // ====================================================
   // conversion timer
   always_ff @(posedge REF_CLK) begin
      conv_end <= 1'b0;
      if (SRST) begin
         ct_cnt <= CTW'(CT_FAST_CYC - 1);
      end else if (ct_cnt == '0) begin
         conv_end <= 1'b1;
         ct_cnt   <= cfg[`MIP_CFG_CT_SEL] ? CTW'(CT_SLOW_CYC - 1)
                                          : CTW'(CT_FAST_CYC - 1);
      end else begin
         ct_cnt <= ct_cnt - CTW'(1);
      end
   end

   // ====================================================
   // averaging over one conversion
   always_ff @(posedge REF_CLK) begin
      if (SRST || conv_end) begin
         acc_shunt <= 24'sh000000;
         acc_bus   <= 24'h000000;
         n_smp     <= '0;
      end else if (smp.valid && n_smp != (AVG_SHIFT+1)'(NSMP)) begin
         acc_shunt <= acc_shunt + 24'(signed'(smp.shunt));
         acc_bus   <= acc_bus + {8'h00, smp.vbus};
         n_smp     <= n_smp + (AVG_SHIFT+1)'(1);
      end
   end

   // a short conversion keeps the previous result
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         vbus      <= 16'h0000;
         shunt_avg <= 16'sh0000;
      end else if (conv_end && n_smp == (AVG_SHIFT+1)'(NSMP)) begin
         vbus      <= 16'(acc_bus >> AVG_SHIFT);
         shunt_avg <= 16'(acc_shunt >>> AVG_SHIFT);
      end
   end

   // ====================================================
   // scaling: current from calibration, power at 25 current LSBs
   assign cur_prod = 32'(shunt_avg * $signed({1'b0, cal}));
   assign pwr_prod = 48'(cur * $signed({1'b0, vbus}));

   always_ff @(posedge REF_CLK) begin
      if (SRST || cal == 16'h0000) begin
         cur <= 16'sh0000;
         pwr <= 16'sh0000;
      end else begin
         cur <= 16'(cur_prod >>> `MIP_CUR_SHIFT);
         // bus LSB over 25 folds into one fixed divisor
         pwr <= 16'(pwr_prod / `MIP_PWR_DIV);
      end
   end

   // ====================================================
   // limit checks once scaling has settled
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         chk_pipe <= 2'b00;
      end else begin
         chk_pipe <= {chk_pipe[0], conv_end};
      end
   end

   assign fault = (vbus > ov_lim) || (cur > $signed(oc_lim));
   // sum already past the scaled limit means the average will be too
   assign early_trip = (acc_bus > {5'h00, ov_lim, 3'h0} >> (3 - AVG_SHIFT));

   // ====================================================
   // alert output, active low
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ALERT_N <= 1'b1;
      end else if (cfg[`MIP_CFG_ALERT_SEL]) begin
         // conversion ready: a new result beats a read in the same cycle
         if (chk_pipe[1]) begin
            ALERT_N <= 1'b0;
         end else if (tele_read) begin
            ALERT_N <= 1'b1;
         end
      end else if (early_trip) begin
         ALERT_N <= 1'b0;
      end else if (chk_pipe[1]) begin
         ALERT_N <= ~fault;
      end
   end
endmodule

// ### hdl/mip_map.svh
// command codes, field positions, reset values and timing of the monitor
`ifndef MIP_MAP_SVH
`define MIP_MAP_SVH
// ====================================================
// command codes
`define MIP_CMD_OV_LIM   8'h57
`define MIP_CMD_OC_LIM   8'h5D
`define MIP_CMD_VIN      8'h88
`define MIP_CMD_IIN      8'h89
`define MIP_CMD_VOUT     8'h8B
`define MIP_CMD_IOUT     8'h8C
`define MIP_CMD_PIN      8'h97
`define MIP_CMD_CAL      8'hD4
`define MIP_CMD_CFG      8'hD9
`define MIP_CMD_MODEL    8'hE1
`define MIP_CMD_REV      8'hE2
// ====================================================
// fields and reset values
`define MIP_CFG_ALERT_SEL 0
`define MIP_CFG_CT_SEL    1
`define MIP_CFG_RST       16'h0000
`define MIP_CAL_RST       16'h0000
`define MIP_CAL_MASK      16'h7FFF
`define MIP_LIM_MASK      16'hFFF8
`define MIP_OV_RST        16'h7FF8
`define MIP_OC_RST        16'h7FF8
`define MIP_UNMAPPED      16'hFFFF
`define MIP_CUR_SHIFT     11
`define MIP_PWR_DIV       20000
// ====================================================
// timing
`define MIP_CLK_NS        100
`define MIP_CT_FAST_NS    140000
`define MIP_CT_SLOW_NS    1100000
`endif

// ### hdl/mip_pkg.sv
// shared types of the monitor
package mip_pkg;
   typedef logic [15:0] mip_word_t;
   typedef logic [7:0]  mip_byte_t;
   typedef enum logic [2:0] {
      MIP_IDLE   = 3'b000,
      MIP_ADDR   = 3'b001,
      MIP_ACK_A  = 3'b010,
      MIP_RX     = 3'b011,
      MIP_ACK_RX = 3'b100,
      MIP_TX     = 3'b101,
      MIP_ACK_TX = 3'b110
   } mip_ser_e;
endpackage

// ### hdl/mip_links.sv
// carriers between the serial engine, the sample crossing and the core
`timescale 1ns/1ns
interface mip_ser_if;
   import mip_pkg::*;
   logic      start;
   logic      stop;
   logic      rx_stb;
   mip_byte_t rx_byte;
   logic      tx_load;
   mip_byte_t tx_byte;
   modport eng (output start, stop, rx_stb, rx_byte, tx_load, input tx_byte);
   modport core (input start, stop, rx_stb, rx_byte, tx_load, output tx_byte);
endinterface

interface mip_smp_if;
   import mip_pkg::*;
   logic      valid;
   mip_word_t shunt;
   mip_word_t vbus;
   modport src (output valid, shunt, vbus);
   modport dst (input valid, shunt, vbus);
endinterface

// ### hdl/mip_serial.sv
// two-wire serial slave engine, oversampled on the reference clock
`timescale 1ns/1ns
module mip_serial #(
   parameter logic [6:0] SLAVE_ADDR = 7'h40
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // to core
   mip_ser_if.eng    ser
);
   import mip_pkg::*;
   logic [2:0] scl_s, sda_s;
   logic       scl_f, sda_f, scl_d, sda_d;
   mip_ser_e   state;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic       rise, fall, start_c, stop_c;

   // ====================================================
   // pin filters: a change counts once stages two and three agree
   always_ff @(posedge clk) begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      if (srst) begin
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
         if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   assign rise    = scl_f & ~scl_d;
   assign fall    = ~scl_f & scl_d;
   assign start_c = scl_f & scl_d & sda_d & ~sda_f;
   assign stop_c  = scl_f & scl_d & ~sda_d & sda_f;

   // ====================================================
   // bit engine
   always_ff @(posedge clk) begin
      ser.start   <= 1'b0;
      ser.stop    <= 1'b0;
      ser.rx_stb  <= 1'b0;
      ser.tx_load <= 1'b0;
      sda_out     <= 1'b0;
      if (srst) begin
         state  <= MIP_IDLE;
         cnt    <= 4'h0;
         sh     <= 8'h00;
         sda_oe <= 1'b0;
         ser.rx_byte <= 8'h00;
      end else if (start_c) begin
         state     <= MIP_ADDR;
         cnt       <= 4'h0;
         sda_oe    <= 1'b0;
         ser.start <= 1'b1;
      end else if (stop_c) begin
         state    <= MIP_IDLE;
         sda_oe   <= 1'b0;
         ser.stop <= 1'b1;
      end else begin
         unique case (state)
            MIP_IDLE: ;
            MIP_ADDR, MIP_RX: begin
               if (rise && cnt != 4'h8) begin
                  sh  <= {sh[6:0], sda_f};
                  cnt <= cnt + 4'h1;
               end else if (fall && cnt == 4'h8) begin
                  if (state == MIP_RX) begin
                     ser.rx_stb  <= 1'b1;
                     ser.rx_byte <= sh;
                     sda_oe      <= 1'b1;
                     state       <= MIP_ACK_RX;
                  end else if (sh[7:1] == SLAVE_ADDR) begin
                     sda_oe <= 1'b1;
                     state  <= MIP_ACK_A;
                  end else begin
                     state <= MIP_IDLE;
                  end
               end
            end
            MIP_ACK_A, MIP_ACK_RX: begin
               if (fall) begin
                  if (state == MIP_ACK_A && sh[0]) begin
                     sh          <= ser.tx_byte;
                     sda_oe      <= ~ser.tx_byte[7];
                     ser.tx_load <= 1'b1;
                     cnt         <= 4'h1;
                     state       <= MIP_TX;
                  end else begin
                     sda_oe <= 1'b0;
                     cnt    <= 4'h0;
                     state  <= MIP_RX;
                  end
               end
            end
            MIP_TX: begin
               if (fall) begin
                  if (cnt == 4'h8) begin
                     sda_oe <= 1'b0;
                     state  <= MIP_ACK_TX;
                  end else begin
                     sh     <= {sh[6:0], 1'b0};
                     sda_oe <= ~sh[6];
                     cnt    <= cnt + 4'h1;
                  end
               end
            end
            MIP_ACK_TX: begin
               // host low on the ack bit asks for another byte
               if (rise) begin
                  cnt <= sda_f ? 4'h0 : 4'h1;
               end else if (fall) begin
                  if (cnt == 4'h1) begin
                     sh          <= ser.tx_byte;
                     sda_oe      <= ~ser.tx_byte[7];
                     ser.tx_load <= 1'b1;
                     state       <= MIP_TX;
                  end else begin
                     state <= MIP_IDLE;
                  end
               end
            end
            default: state <= MIP_IDLE;
         endcase
      end
   end
endmodule

// ### hdl/mip_xfer.sv
// toggle handshake carrying converter samples into the reference domain
`timescale 1ns/1ns
module mip_xfer (
   // converter side
   input  wire logic        adc_clk,
   input  wire logic        adc_srst,
   input  wire logic        adc_valid,
   input  wire logic [15:0] adc_shunt,
   input  wire logic [15:0] adc_bus,
   // reference side
   input  wire logic        clk,
   input  wire logic        srst,
   mip_smp_if.src           smp
);
   import mip_pkg::*;
   logic       req, ack_seen;
   logic [2:0] ack_s, req_s;
   logic       req_seen;
   mip_word_t  hold_shunt, hold_bus;

   // ====================================================
   // converter domain: sample dropped while the previous one is in flight
   always_ff @(posedge adc_clk) begin
      ack_s <= {ack_s[1:0], req_seen};
      if (adc_srst) begin
         req        <= 1'b0;
         ack_seen   <= 1'b0;
         hold_shunt <= 16'h0000;
         hold_bus   <= 16'h0000;
      end else begin
         if (ack_s[1] == ack_s[2]) ack_seen <= ack_s[2];
         if (adc_valid && req == ack_seen) begin
            hold_shunt <= adc_shunt;
            hold_bus   <= adc_bus;
            req        <= ~req;
         end
      end
   end

   // ====================================================
   // reference domain: held words are stable while req and ack differ
   always_ff @(posedge clk) begin
      req_s     <= {req_s[1:0], req};
      smp.valid <= 1'b0;
      if (srst) begin
         req_seen  <= 1'b0;
         smp.shunt <= 16'h0000;
         smp.vbus  <= 16'h0000;
      end else if (req_s[1] == req_s[2] && req_s[2] != req_seen) begin
         req_seen  <= req_s[2];
         smp.valid <= 1'b1;
         smp.shunt <= hold_shunt;
         smp.vbus  <= hold_bus;
      end
   end
endmodule

// ### testbench/mip_top_monitor.sv
// pin-level checker of the monitor core
`timescale 1ns/1ns
module mip_top_monitor (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SRST,
   // pins
   input wire logic SCL_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic ALERT_N
);
   logic [3:0] since;
   logic [3:0] low_cnt;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   always_ff @(posedge REF_CLK) begin
      if (SRST) since <= 4'h0;
      else if (since != 4'hF) since <= since + 4'h1;
   end
   // length of the current low phase of the serial clock pin
   always_ff @(posedge REF_CLK) begin
      if (SCL_IN) low_cnt <= 4'h0;
      else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
   end
   // ====================================================
   // assertions and cover points
   a_sda_out_low: assert property (SDA_OUT == 1'b0)
      else $error("data drive value not zero");
   a_reset_idle: assert property ($fell(SRST) |-> !SDA_OE && ALERT_N)
      else $error("pins not idle after reset");
   a_oe_rise_lag: assert property ($rose(SDA_OE) |-> low_cnt inside {[4'h1:4'h5]})
      else $error("pull-down not launched from a clock fall");
   a_oe_fall_lag: assert property ($fell(SDA_OE) |-> low_cnt inside {[4'h1:4'h5]})
      else $error("release not launched from a clock fall");
   a_oe_stands: assert property ($rose(SDA_OE) |=> SDA_OE [*4])
      else $error("pull-down shorter than a clock low phase");
   a_oe_scl_high: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
      else $error("data changed while clock high");
   a_oe_quiet_start: assert property (since < 4'hF |-> !SDA_OE)
      else $error("pull-down before any frame");
   a_alert_quiet_start: assert property (since < 4'h8 |-> ALERT_N)
      else $error("alert before any conversion");
   c_ack: cover property ($rose(SDA_OE));
   c_alert_set: cover property ($fell(ALERT_N));
   c_alert_clear: cover property ($rose(ALERT_N));
endmodule

// ### testbench/mip_host_model.sv
// two-wire host controller issuing word writes and word reads
`timescale 1ns/1ns
module mip_host_model #(
   parameter logic [6:0] ADDR = 7'h40
) (
   // clock
   input  wire logic clk,
   // wire level and drive
   input  wire logic sda,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // data moves mid-low; sampled at the end of the high phase
   task automatic bit_slot(input logic b, output logic r);
      scl <= 1'b0;
      cyc(3);
      sda_drv <= b;
      cyc(3);
      scl <= 1'b1;
      cyc(6);
      r = sda;
   endtask
   task automatic frame();
      logic r;
      bit_slot(1'b1, r);
      sda_drv <= 1'b0;
      cyc(6);
   endtask
   task automatic halt();
      logic r;
      bit_slot(1'b0, r);
      sda_drv <= 1'b1;
      cyc(6);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
      bit_slot(1'b1, r);
      ack = ~r;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
      bit_slot(last, r);
   endtask
   task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
                             input logic [15:0] w, output logic ok);
      logic [3:0] k;
      frame();
      put_byte({a, 1'b0}, k[0]);
      put_byte(cmd, k[1]);
      put_byte(w[7:0], k[2]);
      put_byte(w[15:8], k[3]);
      halt();
      ok = &k;
   endtask
   // first byte lands in the upper half of w
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] w,
                            output logic ok);
      logic [2:0] k;
      frame();
      put_byte({ADDR, 1'b0}, k[0]);
      put_byte(cmd, k[1]);
      frame();
      put_byte({ADDR, 1'b1}, k[2]);
      get_byte(1'b0, w[15:8]);
      get_byte(1'b1, w[7:0]);
      halt();
      ok = &k;
   endtask
endmodule

// ### testbench/test_monitor_id_scaling_alert_regs.sv
// self-checking bench of the monitor core
`timescale 1ns/1ns
`include "mip_map.svh"
module test_monitor_id_scaling_alert_regs;
   localparam int          FAST  = 80;
   localparam int          SLOW  = 2000;
   localparam logic [15:0] MODEL = 16'hC3A5; // arbitrary
   localparam logic [15:0] REV   = 16'h0217; // arbitrary
   localparam logic [15:0] SHUNT = 16'h0400;
   localparam logic [15:0] VBUS  = 16'h0FA0;
   localparam logic [15:0] CAL   = 16'h0A00;
   logic        REF_CLK, SRST, SCL_IN, SDA_OUT, SDA_OE, host_sda;
   logic        ADC_CLK, ADC_SRST, ADC_VALID, ALERT_N, ok;
   wire         SDA_IN = host_sda & ~SDA_OE;
   logic [3:0]  adc_div = 4'h0;
   logic [15:0] rd;
   logic [7:0]  c;
   int          failures, num_checks, cyc_cnt, t1, t0;
   mip_top #(.MODEL_WORD(MODEL), .REVISION_WORD(REV), .CT_FAST_CYC(FAST),
             .CT_SLOW_CYC(SLOW)) DUT (
      .REF_CLK(REF_CLK), .SRST(SRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
      .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADC_CLK(ADC_CLK),
      .ADC_SRST(ADC_SRST), .ADC_VALID(ADC_VALID), .ADC_SHUNT(SHUNT),
      .ADC_BUS(VBUS), .ALERT_N(ALERT_N));
   mip_host_model #(.ADDR(7'h40)) host (
      .clk(REF_CLK), .sda(SDA_IN), .scl(SCL_IN), .sda_drv(host_sda));
   initial begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end
   initial begin
      ADC_CLK = 1'b0;
      #3;
      forever begin
         #7 ADC_CLK = 1'b1;
         #8 ADC_CLK = 1'b0;
      end
   end
   // one sample every 16 converter cycles; the crossing drops those that arrive while one is in flight
   always @(posedge ADC_CLK) begin
      adc_div <= adc_div + 4'h1;
      ADC_VALID <= (adc_div == 4'h0) && !ADC_SRST;
   end
   always @(posedge REF_CLK) cyc_cnt <= cyc_cnt + 1;
   // ====================================================
   // checks and accesses
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wait_alert(input logic lvl, input int lim);
      int n;
      n = 0;
      @(negedge REF_CLK);
      while (ALERT_N !== lvl && n < lim) begin
         @(negedge REF_CLK);
         n++;
      end
      t1 = cyc_cnt;
      chk_bit(ALERT_N, lvl);
      if (n >= lim) results();
      @(posedge REF_CLK);
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] w);
      host.write_word(7'h40, cmd, w, ok);
   endtask
   // low byte arrives first for the measurement and setting codes
   task automatic rd_low(input logic [7:0] cmd, input logic [15:0] exp);
      host.read_word(cmd, rd, ok);
      chk_word({rd[7:0], rd[15:8]}, exp);
   endtask
   initial begin
      SRST = 1'b1;
      ADC_SRST = 1'b1;
      failures = 0;
      num_checks = 0;
      repeat (6) @(posedge REF_CLK);
      SRST <= 1'b0;
      @(posedge ADC_CLK);
      ADC_SRST <= 1'b0;
      repeat (8) @(posedge REF_CLK);
      host.read_word(`MIP_CMD_MODEL, rd, ok);
      chk_word(rd, MODEL);
      host.read_word(`MIP_CMD_REV, rd, ok);
      chk_word(rd, REV);
      wr(`MIP_CMD_MODEL, 16'h1234);
      wr(`MIP_CMD_REV, 16'h1234);
      chk_bit(ok, 1'b1);
      host.read_word(`MIP_CMD_MODEL, rd, ok);
      chk_word(rd, MODEL);
      host.read_word(`MIP_CMD_REV, rd, ok);
      chk_word(rd, REV);
      host.write_word(7'h41, `MIP_CMD_CAL, CAL, ok);
      chk_bit(ok, 1'b0);
      for (int i = 0; i < 2; i++) begin
         c = (i == 0) ? `MIP_CMD_OV_LIM : `MIP_CMD_OC_LIM;
         rd_low(c, (i == 0) ? `MIP_OV_RST : `MIP_OC_RST);
         wr(c, 16'h3A9F);
         rd_low(c, 16'h3A98);
      end
      rd_low(`MIP_CMD_CAL, `MIP_CAL_RST);
      rd_low(`MIP_CMD_IIN, 16'h0000);
      rd_low(`MIP_CMD_PIN, 16'h0000);
      rd_low(`MIP_CMD_VIN, VBUS);
      wr(`MIP_CMD_CAL, CAL);
      rd_low(`MIP_CMD_CAL, CAL);
      repeat (3 * FAST) @(posedge REF_CLK);
      rd_low(`MIP_CMD_IOUT, 16'h0500);
      rd_low(`MIP_CMD_PIN, 16'h0100);
      rd_low(`MIP_CMD_VOUT, VBUS);
      chk_bit(ALERT_N, 1'b1);
      wr(`MIP_CMD_OV_LIM, 16'h0F98);
      wait_alert(1'b0, 2 * FAST + 8);
      wr(`MIP_CMD_OV_LIM, 16'h3A98);
      wait_alert(1'b1, 2 * FAST + 8);
      wr(`MIP_CMD_OV_LIM, 16'h0008);
      wait_alert(1'b0, FAST / 4);
      wr(`MIP_CMD_OV_LIM, 16'h3A98);
      wait_alert(1'b1, 2 * FAST + 8);
      wr(`MIP_CMD_CFG, 16'h0003);
      wait_alert(1'b0, SLOW + 8);
      // the first fall may come before polling starts, so time two later ones
      for (int i = 0; i < 2; i++) begin
         t0 = t1;
         rd_low(`MIP_CMD_VIN, VBUS);
         wait_alert(1'b1, 4);
         wait_alert(1'b0, SLOW + 8);
      end
      chk_word(16'(t1 - t0), 16'(SLOW));
      results();
   end
endmodule
bind mip_top mip_top_monitor u_mon (
   .REF_CLK(REF_CLK), .SRST(SRST),
   .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ALERT_N(ALERT_N));
